// ### verilog/processor_reset_clock_unit.sv
// Reset and clock front end of the I/O processor
`timescale 1ns/10ps
`default_nettype none

module processor_reset_clock_unit (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic reset_in_n,
    input wire logic [2:0] core_status,
    output logic system_clock_out,
    output logic reset_out,
    output logic fetch_start,
    output logic core_run,
    output logic [2:0] status_out,
    output logic status_oe_n
);

    // ****************************************
    // Clock divider
    // ****************************************
    // A toggle flop gives an exact half rate with a 50% duty cycle,
    // which a counter-based divider with odd ratios could not.
    logic system_clock_reg;
    logic system_clock_next;

    assign system_clock_next = ~system_clock_reg;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            system_clock_reg <= 1'b0;
        end else begin
            system_clock_reg <= system_clock_next;
        end
    end

    // A processor clock edge is the reference edge on which the
    // divided clock rises; the state register moves only then.
    logic proc_tick;

    assign proc_tick = ~system_clock_reg;

    // ****************************************
    // Reset input synchroniser
    // ****************************************
    // The reset input may change at any time relative to ref_clk.
    // Reset value low keeps the sequencer dormant until the pin is really seen high
    logic reset_in_sync;

    sync_two_ff #(
        .RESET_VALUE(1'b0)
    ) u_reset_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .async_in(reset_in_n),
        .sync_out(reset_in_sync)
    );

    logic reset_seen_low;
    logic reset_seen_high;

    // A pulse shorter than a processor clock may be missed; the
    // reset source is expected to hold the input low long enough.
    assign reset_seen_low = proc_tick & ~reset_in_sync;
    assign reset_seen_high = proc_tick & reset_in_sync;

    // ****************************************
    // Sequencer state
    // ****************************************
    reset_clock_pkg::seq_state_t state_reg;
    reset_clock_pkg::seq_state_t state_next;
    logic [2:0] fetch_count_reg;
    logic [2:0] fetch_count_next;

    logic in_run;
    logic in_drive_idle;
    logic in_dormant;
    logic in_wake;

    assign in_run = (state_reg == reset_clock_pkg::SEQ_RUN);
    assign in_drive_idle = (state_reg == reset_clock_pkg::SEQ_DRIVE_IDLE);
    assign in_dormant = (state_reg == reset_clock_pkg::SEQ_DORMANT);
    assign in_wake = (state_reg == reset_clock_pkg::SEQ_WAKE);

    logic fetch_due;

    assign fetch_due = in_wake & reset_seen_high
        & (fetch_count_reg == reset_clock_pkg::FETCH_COUNT_LAST);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            reset_clock_pkg::SEQ_RUN: begin
                if (reset_seen_low) begin
                    state_next = reset_clock_pkg::SEQ_DRIVE_IDLE;
                end
            end
            reset_clock_pkg::SEQ_DRIVE_IDLE: begin
                // One processor clock of idle drive, then the lines float
                if (proc_tick) begin
                    state_next = reset_clock_pkg::SEQ_DORMANT;
                end
            end
            reset_clock_pkg::SEQ_DORMANT: begin
                if (reset_seen_high) begin
                    state_next = reset_clock_pkg::SEQ_WAKE;
                end
            end
            reset_clock_pkg::SEQ_WAKE: begin
                if (reset_seen_low) begin
                    // Status lines already float, so skip the idle drive
                    state_next = reset_clock_pkg::SEQ_DORMANT;
                end else if (fetch_due) begin
                    state_next = reset_clock_pkg::SEQ_RUN;
                end
            end
            default: begin
                state_next = reset_clock_pkg::SEQ_DORMANT;
            end
        endcase
    end

    // Wake-up counter restarts each time reset is re-entered
    // It reaches the last count on the sixth tick, so the seventh fires the fetch
    logic fetch_count_step;

    assign fetch_count_step = in_wake & reset_seen_high;
    assign fetch_count_next = fetch_count_step ? (fetch_count_reg + 3'h1)
        : (in_wake ? fetch_count_reg : reset_clock_pkg::FETCH_COUNT_RESET);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_reg <= reset_clock_pkg::SEQ_DORMANT;
            fetch_count_reg <= reset_clock_pkg::FETCH_COUNT_RESET;
        end else begin
            state_reg <= state_next;
            fetch_count_reg <= fetch_count_next;
        end
    end

    // ****************************************
    // Reset output
    // ****************************************
    // Changes only on a processor clock edge, the same edge on which the
    // synchronised input is seen, so its width is whole periods.
    logic reset_out_next;

    assign reset_out_next = reset_seen_low ? 1'b1
        : (reset_seen_high ? 1'b0 : reset_out);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            reset_out <= 1'b1;
        end else begin
            reset_out <= reset_out_next;
        end
    end

    // ****************************************
    // Core run and fetch start
    // ****************************************
    // Run drops on the same tick that raises the reset output
    logic core_run_next;
    logic fetch_start_next;

    assign core_run_next = (in_run & ~reset_seen_low) | fetch_due;
    assign fetch_start_next = fetch_due;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            core_run <= 1'b0;
            fetch_start <= 1'b0;
        end else begin
            core_run <= core_run_next;
            fetch_start <= fetch_start_next;
        end
    end

    // ****************************************
    // Bus status lines
    // ****************************************
    // During run the core's status passes through one register so
    // the pins stay flop-driven; this costs one reference cycle.
    // Lines float from power-up until the first fetch.
    logic [2:0] status_next;
    logic status_oe_n_next;
    logic status_drive;

    assign status_drive = (in_run & ~reset_seen_low) | fetch_due;
    assign status_next = status_drive ? core_status
        : reset_clock_pkg::STATUS_INACTIVE;
    assign status_oe_n_next = ~(status_drive | (in_run & reset_seen_low)
        | (in_drive_idle & ~proc_tick));

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            status_out <= reset_clock_pkg::STATUS_INACTIVE;
            status_oe_n <= 1'b1;
        end else begin
            status_out <= status_next;
            status_oe_n <= status_oe_n_next;
        end
    end

    // ****************************************
    // Divided clock output
    // ****************************************
    // No gate sits between the toggle flop and the pin
    assign system_clock_out = system_clock_reg;

endmodule // processor_reset_clock_unit

`default_nettype wire

// ### verilog/reset_clock_pkg.sv
// Constants shared by the reset and clock front end
package reset_clock_pkg;

    // ****************************************
    // Clock division
    // ****************************************
    localparam int CLOCK_DIVIDE = 2;
    localparam int REF_CLOCK_HZ = 10000000;

    // ****************************************
    // Reset timing, in processor clock cycles; the power-up release in microseconds and reference cycles
    // ****************************************
    localparam int RESET_MIN_LOW_CYCLES = 4;
    localparam int FETCH_DELAY_CYCLES = 7;
    localparam logic [2:0] FETCH_COUNT_LAST = 3'h6;
    localparam logic [2:0] FETCH_COUNT_RESET = 3'h0;

    // Power-up release delay owed by the reset source
    localparam int POWER_UP_RELEASE_US = 50;
    localparam int POWER_UP_RELEASE_REF_CYCLES =
        (POWER_UP_RELEASE_US * (REF_CLOCK_HZ / 1000000) + 999999 * 0);

    // ****************************************
    // Bus status lines
    // ****************************************
    localparam int STATUS_WIDTH = 3;
    localparam logic [2:0] STATUS_INACTIVE = 3'h7;

    // ****************************************
    // Sequencer states
    // ****************************************
    typedef enum logic [1:0] {
        SEQ_RUN = 2'b00,
        SEQ_DRIVE_IDLE = 2'b01,
        SEQ_DORMANT = 2'b10,
        SEQ_WAKE = 2'b11
    } seq_state_t;

endpackage

// ### verilog/sync_two_ff.sv
// Two flip-flop synchroniser for one asynchronous level
`timescale 1ns/10ps
`default_nettype none

module sync_two_ff #(
    parameter logic RESET_VALUE = 1'b0
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic async_in,
    output logic sync_out
);

    // ****************************************
    // Synchroniser
    // ****************************************
    // First stage is read only by the second stage
    logic meta_reg;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta_reg <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule // sync_two_ff

`default_nettype wire

// ### test/reset_clock_chk.sv
// Assertion checker for the reset and clock front end
`timescale 1ns/10ps
`default_nettype none

module reset_clock_chk (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic reset_in_n,
    input wire logic [2:0] core_status,
    input wire logic system_clock_out,
    input wire logic reset_out,
    input wire logic fetch_start,
    input wire logic core_run,
    input wire logic [2:0] status_out,
    input wire logic status_oe_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // ****************************************
    // Properties
    // ****************************************
    property p_div; !$past(reset) && !$past(reset, 2) |-> system_clock_out != $past(system_clock_out); endproperty
    a_div: assert property (p_div) else $error("clock output not halved");
    property p_duty; $rose(system_clock_out) |=> $fell(system_clock_out); endproperty
    a_duty: assert property (p_duty) else $error("clock high time wrong");
    property p_whole; $changed(reset_out) |-> system_clock_out; endproperty
    a_whole: assert property (p_whole) else $error("reset output moved off a clock period");
    property p_dormant; reset_out |-> !core_run && !fetch_start; endproperty
    a_dormant: assert property (p_dormant) else $error("core active during reset");
    // Synchroniser delay: the input must not act on the very next edge
    property p_sync; $fell(reset_in_n) && !reset_out |=> !reset_out; endproperty
    a_sync: assert property (p_sync) else $error("reset input not synchronised");
    property p_assert; !reset_in_n [*5] |-> reset_out; endproperty
    a_assert: assert property (p_assert) else $error("reset output late");
    property p_wake; $fell(reset_out) |-> !core_run [*8]; endproperty
    a_wake: assert property (p_wake) else $error("core ran early in wake-up");
    // A reset re-entered during wake-up restarts the count, so only an unbroken wake is timed
    property p_fetch; $fell(reset_out) ##1 !reset_out [*8] ##6 !reset_out |-> fetch_start && core_run; endproperty
    a_fetch: assert property (p_fetch) else $error("first fetch not seven clocks after reset");
    property p_pulse; fetch_start |=> !fetch_start; endproperty
    a_pulse: assert property (p_pulse) else $error("fetch pulse too long");
    property p_idle;
        $rose(reset_out) && $past(core_run) |->
            (!status_oe_n && status_out == reset_clock_pkg::STATUS_INACTIVE) [*2] ##1 status_oe_n;
    endproperty
    a_idle: assert property (p_idle) else $error("status lines not idled then floated");
endmodule // reset_clock_chk

bind processor_reset_clock_unit reset_clock_chk reset_clock_chk_inst (.ref_clk(ref_clk), .reset(reset),
    .reset_in_n(reset_in_n), .core_status(core_status), .system_clock_out(system_clock_out),
    .reset_out(reset_out), .fetch_start(fetch_start), .core_run(core_run), .status_out(status_out),
    .status_oe_n(status_oe_n));

`default_nettype wire

// ### test/reset_source_model.sv
// Model of the external power-on reset source
`timescale 1ns/10ps
`default_nettype none

module reset_source_model (
    input wire logic ref_clk,
    output logic reset_in_n
);
    initial begin
        reset_in_n = 1'b0;
        repeat (reset_clock_pkg::POWER_UP_RELEASE_REF_CYCLES) @(negedge ref_clk);
        #13 reset_in_n = 1'b1;
    end

    // Short requests are stretched: a real source never cuts a pulse short
    task automatic pulse(input int proc_cycles, input int skew);
        int n;
        n = (proc_cycles > reset_clock_pkg::RESET_MIN_LOW_CYCLES) ? proc_cycles
            : reset_clock_pkg::RESET_MIN_LOW_CYCLES + 1;
        @(negedge ref_clk);
        #(skew) reset_in_n = 1'b0;
        repeat (2 * n) @(negedge ref_clk);
        #(skew) reset_in_n = 1'b1;
    endtask
endmodule // reset_source_model

`default_nettype wire

// ### test/processor_reset_clock_unit_tb_top.sv
// Self-checking testbench of the reset and clock front end
`timescale 1ns/10ps
`default_nettype none

module processor_reset_clock_unit_tb_top;
    logic ref_clk, reset, reset_in_n, system_clock_out, reset_out, fetch_start, core_run, status_oe_n, prev;
    logic [2:0] core_status, status_out;
    integer seed = 32'h876ac0bd;
    int n_errors = 0;
    int checks_done = 0;
    int k, w, low, hi;

    processor_reset_clock_unit processor_reset_clock_unit_inst (.ref_clk(ref_clk), .reset(reset),
        .reset_in_n(reset_in_n), .core_status(core_status), .system_clock_out(system_clock_out),
        .reset_out(reset_out), .fetch_start(fetch_start), .core_run(core_run), .status_out(status_out),
        .status_oe_n(status_oe_n));
    reset_source_model reset_source_model_inst (.ref_clk(ref_clk), .reset_in_n(reset_in_n));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic tracks(input int width, input int l);
        return (width % 2 == 0) && (width >= 2 * l - 2) && (width <= 2 * l + 2);
    endfunction

    task automatic stop_test();
        if (n_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Watches reset_out when on_reset is set, fetch_start otherwise
    task automatic wait_level(input logic on_reset, input logic lvl, input int bound, output int cnt);
        cnt = 0;
        while ((on_reset ? reset_out : fetch_start) !== lvl) begin
            @(negedge ref_clk);
            cnt++;
            if (cnt > bound) begin
                n_errors++;
                stop_test();
            end
        end
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        reset = 1'b1;
        core_status = 3'h0;
        repeat (12) @(negedge ref_clk);
        reset = 1'b0;
        wait_level(1'b0, 1'b1, 700, k);
        for (int i = 0; i < 8; i++) begin
            // Corner lengths first: the shortest legal pulse, then a long one
            low = (i == 0) ? 5 : (i == 1) ? 12 : 5 + ($random(seed) & 7);
            fork
                reset_source_model_inst.pulse(low, $random(seed) & 31);
            join_none
            wait_level(1'b1, 1'b1, 12, k);
            check({4'h0, status_oe_n, status_out}, {4'h0, 1'b0, reset_clock_pkg::STATUS_INACTIVE});
            check({7'h0, core_run}, 8'h0);
            repeat (2) @(negedge ref_clk);
            check({7'h0, status_oe_n}, 8'h1);
            wait_level(1'b1, 1'b0, 40, w);
            check({7'h0, tracks(w + 2, low)}, 8'h1);
            if (i == 2) begin
                // Reset again while waking: the lines already float and the count restarts
                fork
                    reset_source_model_inst.pulse(5, $random(seed) & 31);
                join_none
                wait_level(1'b1, 1'b1, 12, k);
                check({7'h0, status_oe_n}, 8'h1);
                check({7'h0, core_run}, 8'h0);
                wait_level(1'b1, 1'b0, 40, w);
                check({7'h0, tracks(w, 5)}, 8'h1);
            end
            wait_level(1'b0, 1'b1, 20, k);
            check(8'(k), 8'(2 * reset_clock_pkg::FETCH_DELAY_CYCLES));
            hi = 0;
            for (int j = 0; j < 4; j++) begin
                prev = system_clock_out;
                core_status = 3'($random(seed));
                @(negedge ref_clk);
                hi += system_clock_out;
                check({7'h0, system_clock_out}, {7'h0, ~prev});
                check({4'h0, status_oe_n, status_out}, {4'h0, 1'b0, core_status});
            end
            check(8'(hi), 8'h2);
        end
        stop_test();
    end
endmodule // processor_reset_clock_unit_tb_top

`default_nettype wire
